// [src/csr_bank_params.svh]
// Constants for the indirect register bank: indices, bit positions, timings.
// Assumes inclusion by csr_bank_pkg and the bank module only.
`ifndef CSR_BANK_PARAMS_SVH
`define CSR_BANK_PARAMS_SVH

// Pointer field width and the register indices
`define PTR_W 7
`define IDX_STATUS 7'h00
`define IDX_MASK 7'h03
`define IDX_FEATURE 7'h04
`define IDX_MODE 7'h0F

// Status register bit positions
`define B_ANY_FAULT 15
`define B_BABBLE 14
`define B_SQE 13
`define B_LOST 12
`define B_GRANT 11
`define B_RX_DONE 10
`define B_TX_DONE 9
`define B_SETUP 8
`define B_IRQ_PEND 7
`define B_IRQ_EN 6
`define B_RX_ACT 5
`define B_TX_ACT 4
`define B_POLL 3
`define B_STOP 2
`define B_RUN 1
`define B_INIT 0

// Mask register bit positions
`define M_BABBLE 14
`define M_LOST 12
`define M_GRANT 11
`define M_RX_DONE 10
`define M_TX_DONE 9
`define M_SETUP 8

// Mode register bits for the receive and transmit disables
`define D_RX 0
`define D_TX 1

// Bus grant wait: 50 us at 50 MHz, rounded down
`define GRANT_WAIT_NS 50000
`define CLK_PERIOD_NS 20
`define GRANT_WAIT_CYC (`GRANT_WAIT_NS / `CLK_PERIOD_NS)

// Babble threshold in bytes per frame
`define BABBLE_BYTES 1519
// SQE window in bit times
`define SQE_BIT_TIMES 20

`endif

// [src/csr_bank_pkg.sv]
// Types shared by the indirect register bank and its bench.
// Assumes csr_bank_params.svh is on the include path.
`default_nettype none
`include "csr_bank_params.svh"

package csr_bank_pkg;

   // Host access to one of the three ports
   typedef enum logic [1:0] {
      PORT_POINTER = 2'b00,
      PORT_MAIN = 2'b01,
      PORT_BUSCFG = 2'b10,
      PORT_NONE = 2'b11
   } port_sel_e;

   // One host cycle: port, write strobe, read strobe, data
   typedef struct packed {
      port_sel_e port;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } host_req_s;

   // Events from the engine, one-cycle pulses: flag sets, poll fetch taken and direct interrupt causes
   typedef struct packed {
      logic babble;
      logic sqe;
      logic lost;
      logic rx_done;
      logic tx_done;
      logic setup_done;
      logic poll_taken;
      logic missed_ovf;
      logic coll_ovf;
      logic overlong;
      logic tx_begin;
   } events_s;

   // Grant wait state
   typedef enum logic [1:0] {
      G_IDLE = 2'b00,
      G_WAIT = 2'b01,
      G_DONE = 2'b10
   } grant_e;

endpackage

`default_nettype wire

// [src/csr_status_bank.sv]
// Indirect register access ports and the controller status register.
// Assumes events are synchronous one-cycle pulses from the engine on clk;
// bus-grant acknowledge and link-fail come from pins and are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "csr_bank_params.svh"

module csr_status_bank
   import csr_bank_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Host port access
   input wire host_req_s req,
   output logic [15:0] rdata,
   // Engine events
   input wire events_s ev,
   input wire logic sqe_missing,
   input wire logic link_fail_tx,
   // Bus master handshake
   input wire logic bus_req,
   input wire logic bus_ack_pin,
   // Bus config register read data for the current index
   input wire logic [15:0] buscfg_rdata,
   // Register values out to the rest of the chip
   output logic [15:0] status,
   output logic [15:0] mask_reg,
   output logic [15:0] mode_reg,
   output logic [6:0] pointer,
   output logic buscfg_wr,
   output logic [15:0] buscfg_wdata,
   output logic poll_req,
   output logic irq
);

   // Internal state
   logic babble_fault, sqe_test_fault, lost_frame_flag, bus_grant_timeout;
   logic rx_done_flag, tx_done_flag, setup_loaded_flag;
   logic irq_enable, rx_active, tx_active, tx_poll_now;
   logic stop_bit, run_cmd, init_cmd, wait_init;
   logic ack_meta, ack_sync, fail_meta, fail_sync;
   logic [15:0] mask_q, mode_q;
   logic [6:0] ptr;
   logic [15:0] grant_cnt;
   grant_e grant_st;
   logic grant_fire;

   // Decoded main-port writes to the status, mask and mode registers
   logic st_wr, mk_wr, md_wr;
   logic [15:0] wd;
   logic stop_now, any_fault, irq_pending;
   assign wd = req.wdata;
   assign st_wr = req.wr && req.port == PORT_MAIN && ptr == `IDX_STATUS;
   assign mk_wr = req.wr && req.port == PORT_MAIN && ptr == `IDX_MASK;
   assign md_wr = req.wr && req.port == PORT_MAIN && ptr == `IDX_MODE;
   // Stop outranks run and init written alongside it
   assign stop_now = st_wr && wd[`B_STOP];

   // Pin synchronisers; only the second stage is read
   always_ff @(posedge clk) begin
      if (srst) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
         fail_meta <= 1'b0;
         fail_sync <= 1'b0;
      end else begin
         ack_meta <= bus_ack_pin;
         ack_sync <= ack_meta;
         fail_meta <= link_fail_tx;
         fail_sync <= fail_meta;
      end
   end

   // Pointer register, low seven bits only
   always_ff @(posedge clk) begin
      if (srst) begin
         ptr <= 7'h00;
      end else if (req.wr && req.port == PORT_POINTER) begin
         ptr <= wd[6:0];
      end
   end

   // Mask and mode registers; stop leaves them alone
   always_ff @(posedge clk) begin
      if (srst) begin
         mask_q <= 16'h0000;
         mode_q <= 16'h0000;
      end else begin
         if (mk_wr) begin
            mask_q <= wd;
         end
         if (md_wr) begin
            mode_q <= wd;
         end
      end
   end

   // Grant timer counts while request waits for acknowledge
   always_ff @(posedge clk) begin
      if (srst || stop_bit) begin
         grant_st <= G_IDLE;
         grant_cnt <= 16'h0000;
      end else begin
         case (grant_st)
            G_IDLE: begin
               grant_cnt <= 16'h0000;
               if (bus_req && !ack_sync) begin
                  grant_st <= G_WAIT;
               end
            end
            G_WAIT: begin
               if (!bus_req || ack_sync) begin
                  grant_st <= G_IDLE;
               end else if (grant_cnt == 16'(`GRANT_WAIT_CYC - 1)) begin
                  grant_st <= G_DONE;
               end else begin
                  grant_cnt <= grant_cnt + 16'h0001;
               end
            end
            G_DONE: begin
               // One report per request; wait for it to drop
               if (!bus_req || ack_sync) begin
                  grant_st <= G_IDLE;
               end
            end
            default: grant_st <= G_IDLE;
         endcase
      end
   end
   assign grant_fire = grant_st == G_WAIT && bus_req && !ack_sync && grant_cnt == 16'(`GRANT_WAIT_CYC - 1);

   // Sticky event flags: set wins over a simultaneous write-one clear
   always_ff @(posedge clk) begin
      if (srst || stop_now) begin
         babble_fault <= 1'b0;
         sqe_test_fault <= 1'b0;
         lost_frame_flag <= 1'b0;
         bus_grant_timeout <= 1'b0;
         rx_done_flag <= 1'b0;
         tx_done_flag <= 1'b0;
         setup_loaded_flag <= 1'b0;
      end else begin
         babble_fault <= ev.babble || (babble_fault && !(st_wr && wd[`B_BABBLE]));
         sqe_test_fault <= ev.sqe || sqe_missing || (fail_sync && tx_active)
            || (sqe_test_fault && !(st_wr && wd[`B_SQE]));
         lost_frame_flag <= ev.lost || (lost_frame_flag && !(st_wr && wd[`B_LOST]));
         bus_grant_timeout <= grant_fire || (bus_grant_timeout && !(st_wr && wd[`B_GRANT]));
         rx_done_flag <= ev.rx_done || (rx_done_flag && !(st_wr && wd[`B_RX_DONE]));
         tx_done_flag <= ev.tx_done || (tx_done_flag && !(st_wr && wd[`B_TX_DONE]));
         setup_loaded_flag <= ev.setup_done || (setup_loaded_flag && !(st_wr && wd[`B_SETUP]));
      end
   end

   // Command bits: stop, run, init and the pending-init wait
   always_ff @(posedge clk) begin
      if (srst) begin
         stop_bit <= 1'b1;
         run_cmd <= 1'b0;
         init_cmd <= 1'b0;
         wait_init <= 1'b0;
      end else if (stop_now) begin
         stop_bit <= 1'b1;
         run_cmd <= 1'b0;
         init_cmd <= 1'b0;
         wait_init <= 1'b0;
      end else begin
         if (st_wr && (wd[`B_RUN] || wd[`B_INIT])) begin
            stop_bit <= 1'b0;
         end
         if (st_wr && wd[`B_RUN]) begin
            run_cmd <= 1'b1;
         end
         if (st_wr && wd[`B_INIT]) begin
            init_cmd <= 1'b1;
         end
         if (st_wr && wd[`B_RUN] && wd[`B_INIT]) begin
            wait_init <= 1'b1;
         end else if (ev.setup_done) begin
            wait_init <= 1'b0;
         end
      end
   end

   // Enable, active indications and poll demand
   always_ff @(posedge clk) begin
      if (srst || stop_now) begin
         irq_enable <= 1'b0;
         rx_active <= 1'b0;
         tx_active <= 1'b0;
         tx_poll_now <= 1'b0;
      end else begin
         if (st_wr) begin
            irq_enable <= wd[`B_IRQ_EN];
         end
         // Run alone starts now; run with init waits for setup to load
         if ((st_wr && wd[`B_RUN] && !wd[`B_INIT]) || (wait_init && ev.setup_done)) begin
            rx_active <= !mode_q[`D_RX];
            tx_active <= !mode_q[`D_TX];
         end
         // Demand dropped if transmitter is off; fetch clears it
         if (!tx_active) begin
            tx_poll_now <= 1'b0;
         end else if (st_wr && wd[`B_POLL]) begin
            tx_poll_now <= 1'b1;
         end else if (ev.poll_taken) begin
            tx_poll_now <= 1'b0;
         end
      end
   end

   // Summary bits; sqe fault feeds any_fault but no interrupt cause
   assign any_fault = babble_fault | sqe_test_fault | lost_frame_flag | bus_grant_timeout;
   assign irq_pending = (babble_fault & !mask_q[`M_BABBLE]) | (lost_frame_flag & !mask_q[`M_LOST])
      | (bus_grant_timeout & !mask_q[`M_GRANT]) | (rx_done_flag & !mask_q[`M_RX_DONE])
      | (tx_done_flag & !mask_q[`M_TX_DONE]) | (setup_loaded_flag & !mask_q[`M_SETUP])
      | ev.missed_ovf | ev.coll_ovf | ev.overlong | ev.tx_begin;

   // Registered outputs, one cycle behind the state
   always_ff @(posedge clk) begin
      if (srst) begin
         status <= 16'h0004;
         irq <= 1'b0;
         mask_reg <= 16'h0000;
         mode_reg <= 16'h0000;
         pointer <= 7'h00;
         poll_req <= 1'b0;
         buscfg_wr <= 1'b0;
         buscfg_wdata <= 16'h0000;
      end else begin
         status <= {any_fault, babble_fault, sqe_test_fault, lost_frame_flag, bus_grant_timeout,
            rx_done_flag, tx_done_flag, setup_loaded_flag, irq_pending, irq_enable,
            rx_active, tx_active, tx_poll_now, stop_bit, run_cmd, init_cmd};
         irq <= irq_enable && irq_pending;
         mask_reg <= mask_q;
         mode_reg <= mode_q;
         pointer <= ptr;
         poll_req <= tx_poll_now && tx_active;
         buscfg_wr <= req.wr && req.port == PORT_BUSCFG;
         buscfg_wdata <= wd;
      end
   end

   // Read data path, registered; unmapped indices read zero
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= 16'h0000;
      end else if (req.rd && req.port == PORT_POINTER) begin
         rdata <= {9'h000, ptr};
      end else if (req.rd && req.port == PORT_BUSCFG) begin
         rdata <= buscfg_rdata;
      end else if (req.rd && req.port == PORT_MAIN && ptr == `IDX_STATUS) begin
         rdata <= {any_fault, babble_fault, sqe_test_fault, lost_frame_flag, bus_grant_timeout,
            rx_done_flag, tx_done_flag, setup_loaded_flag, irq_pending, irq_enable,
            rx_active, tx_active, tx_poll_now, stop_bit, run_cmd, init_cmd};
      end else if (req.rd && req.port == PORT_MAIN && ptr == `IDX_MASK) begin
         rdata <= mask_q;
      end else if (req.rd && req.port == PORT_MAIN && ptr == `IDX_MODE) begin
         rdata <= mode_q;
      end else if (req.rd) begin
         rdata <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

// [tb/csr_status_bank_asserts.sv]
// Port-level checker for the indirect status register bank.
// Assumes one clock domain and the package types on the ports.
`timescale 1ns/1ps
`default_nettype none

module csr_status_bank_asserts
   import csr_bank_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched ports
   input wire host_req_s req,
   input wire events_s ev,
   input wire logic sqe_missing,
   input wire logic [15:0] status,
   input wire logic [6:0] pointer,
   input wire logic buscfg_wr,
   input wire logic [15:0] buscfg_wdata,
   input wire logic poll_req,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Status write through the main port at index zero
   sequence s_main_wr;
      req.wr && req.port == PORT_MAIN && pointer == 7'h00;
   endsequence
   // Clear of babble with no new babble for two edges
   sequence s_babble_w1c;
      s_main_wr ##0 (req.wdata[14] && !ev.babble) ##1 !ev.babble;
   endsequence
   // Stop write with quiet engine, so no flag can be set again
   sequence s_stop_wr;
      s_main_wr ##0 (req.wdata[2] && ev == '0 && !sqe_missing) ##1 ev == '0;
   endsequence

   a_fault_summary: assert property (status[15] == (|status[14:11]))
      else $error("fault summary differs from fault flags");
   a_pointer_load: assert property (req.wr && req.port == PORT_POINTER |-> ##2 pointer == $past(req.wdata[6:0], 2))
      else $error("pointer did not take low seven bits");
   a_buscfg_pass: assert property (req.wr && req.port == PORT_BUSCFG |=> buscfg_wr && buscfg_wdata == $past(req.wdata))
      else $error("bus config write not passed on");
   a_reset_state: assert property ($fell(srst) |-> status == 16'h0004 && !irq && pointer == 7'h00)
      else $error("state after reset wrong");
   a_babble_w1c: assert property (s_babble_w1c |=> !status[14])
      else $error("babble flag not cleared by write one");
   a_stop_clears: assert property (s_stop_wr |=> status[2] && status[14] == 1'b0 && status[12:8] == 5'h00 && status[6:4] == 3'h0)
      else $error("stop did not clear flags");
   a_irq_gate: assert property (!status[6] [*3] |-> !irq)
      else $error("interrupt active while disabled");
   a_irq_pending: assert property (irq |-> ##[0:1] (status[7] && status[6]))
      else $error("interrupt without pending and enable");
   a_poll_tx: assert property (poll_req |-> ##[0:1] status[4])
      else $error("poll request while transmit inactive");
endmodule

bind csr_status_bank csr_status_bank_asserts chk (.clk(clk), .srst(srst), .req(req), .ev(ev),
   .sqe_missing(sqe_missing), .status(status), .pointer(pointer), .buscfg_wr(buscfg_wr),
   .buscfg_wdata(buscfg_wdata), .poll_req(poll_req), .irq(irq));

`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the indirect status register bank.
// Assumes the design compiled from src/ with its package.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import csr_bank_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   host_req_s req = '{port: PORT_NONE, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
   events_s ev = '0;
   events_s e;
   logic bus_req = 1'b0;
   logic sqe_missing = 1'b0;
   logic link_fail_tx = 1'b0;
   logic bus_ack_pin = 1'b0;
   logic [15:0] rdata, status, mask_reg, mode_reg, buscfg_wdata;
   logic [6:0] pointer;
   logic buscfg_wr, poll_req, irq;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int b;

   csr_status_bank dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .ev(ev),
      .sqe_missing(sqe_missing), .link_fail_tx(link_fail_tx), .bus_req(bus_req), .bus_ack_pin(bus_ack_pin),
      .buscfg_rdata(16'hA5C3), .status(status), .mask_reg(mask_reg), .mode_reg(mode_reg),
      .pointer(pointer), .buscfg_wr(buscfg_wr), .buscfg_wdata(buscfg_wdata),
      .poll_req(poll_req), .irq(irq));

   always #10 clk = ~clk;

   // Hang guard; the grant wait is the longest step at about 2500 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // One host cycle, then an idle cycle so results have landed
   task automatic access(input port_sel_e p, input logic w, input logic [15:0] d);
      @(negedge clk);
      req <= '{port: p, wr: w, rd: !w, wdata: d};
      @(negedge clk);
      req <= '{port: PORT_NONE, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
      @(negedge clk);
   endtask

   task automatic wreg(input logic [15:0] idx, input logic [15:0] d);
      access(PORT_POINTER, 1'b1, idx);
      access(PORT_MAIN, 1'b1, d);
   endtask

   task automatic rchk(input port_sel_e p, input logic [15:0] exp, input string name);
      access(p, 1'b0, 16'h0000);
      check(name, rdata, exp);
   endtask

   // Event pulses are one cycle; two more cycles let irq settle
   task automatic pulse(input events_s x);
      @(negedge clk);
      ev <= x;
      @(negedge clk);
      ev <= '0;
      repeat (2) @(negedge clk);
   endtask

   initial begin
      repeat (8) @(negedge clk);
      srst <= 1'b0;
      check("status", status, 16'h0004);
      rchk(PORT_MAIN, 16'h0004, "status read");
      access(PORT_POINTER, 1'b1, 16'hFF83);
      check("pointer", {9'h000, pointer}, 16'h0003);
      rchk(PORT_POINTER, 16'h0003, "pointer read");
      wreg(16'h0000, 16'h0002);
      check("run", status, 16'h0032);
      wreg(16'h0000, 16'h0040);
      check("enable", status, 16'h0072);
      // Each maskable flag except bus grant timeout: set, interrupt, clear by write one
      for (int i = 0; i < 5; i++) begin
         e = '0;
         case (i)
            0: begin e.babble = 1'b1; b = 14; end
            1: begin e.lost = 1'b1; b = 12; end
            2: begin e.rx_done = 1'b1; b = 10; end
            3: begin e.tx_done = 1'b1; b = 9; end
            default: begin e.setup_done = 1'b1; b = 8; end
         endcase
         pulse(e);
         check("flag", status, 16'h00F2 | (16'h0001 << b) | ((b >= 12) ? 16'h8000 : 16'h0000));
         check("irq", {15'h0000, irq}, 16'h0001);
         wreg(16'h0000, (16'h0001 << b) | 16'h0040);
         check("cleared", status, 16'h0072);
         check("irq off", {15'h0000, irq}, 16'h0000);
      end
      // Unmasked level causes show in pending only while they stand
      for (int i = 0; i < 4; i++) begin
         e = '0;
         e.missed_ovf = (i == 0);
         e.coll_ovf = (i == 1);
         e.overlong = (i == 2);
         e.tx_begin = (i == 3);
         @(negedge clk);
         ev <= e;
         repeat (2) @(negedge clk);
         check("level cause", status, 16'h00F2);
         check("level irq", {15'h0000, irq}, 16'h0001);
         ev <= '0;
         repeat (2) @(negedge clk);
         check("level gone", status, 16'h0072);
      end
      e = '0;
      e.sqe = 1'b1;
      pulse(e);
      check("sqe", status, 16'hA072);
      check("sqe irq", {15'h0000, irq}, 16'h0000);
      wreg(16'h0000, 16'h2040);
      // Missing collision answer, then link failure while sending
      sqe_missing <= 1'b1;
      @(negedge clk);
      sqe_missing <= 1'b0;
      repeat (2) @(negedge clk);
      check("sqe missing", status, 16'hA072);
      wreg(16'h0000, 16'h2040);
      link_fail_tx <= 1'b1;
      repeat (4) @(negedge clk);
      link_fail_tx <= 1'b0;
      repeat (4) @(negedge clk);
      check("link fail", status, 16'hA072);
      wreg(16'h0000, 16'h2040);
      wreg(16'h0003, 16'h4000);
      check("mask", mask_reg, 16'h4000);
      rchk(PORT_MAIN, 16'h4000, "mask read");
      e = '0;
      e.babble = 1'b1;
      pulse(e);
      check("masked", status, 16'hC072);
      check("masked irq", {15'h0000, irq}, 16'h0000);
      wreg(16'h0000, 16'h0040);
      check("zero write", status, 16'hC072);
      wreg(16'h0000, 16'h4040);
      wreg(16'h0003, 16'h0000);
      // Grant acknowledged in time: no timeout
      bus_req <= 1'b1;
      repeat (100) @(negedge clk);
      bus_ack_pin <= 1'b1;
      repeat (4) @(negedge clk);
      bus_req <= 1'b0;
      bus_ack_pin <= 1'b0;
      repeat (4) @(negedge clk);
      check("grant acked", status, 16'h0072);
      // Grant never acknowledged; 50 us is 2500 cycles
      bus_req <= 1'b1;
      repeat (2490) @(negedge clk);
      check("grant early", status, 16'h0072);
      repeat (30) @(negedge clk);
      check("grant", status, 16'h88F2);
      bus_req <= 1'b0;
      wreg(16'h0000, 16'h0840);
      wreg(16'h0000, 16'h0048);
      check("poll", {15'h0000, poll_req}, 16'h0001);
      e = '0;
      e.poll_taken = 1'b1;
      pulse(e);
      check("poll taken", {status[3], poll_req}, 16'h0000);
      wreg(16'h0000, 16'h0000);
      e = '0;
      e.rx_done = 1'b1;
      pulse(e);
      check("disabled", status, 16'h04B2);
      check("disabled irq", {15'h0000, irq}, 16'h0000);
      wreg(16'h0000, 16'h0004);
      check("stop", status, 16'h0004);
      wreg(16'h0000, 16'h0008);
      check("poll stopped", {status[3], poll_req}, 16'h0000);
      wreg(16'h000F, 16'h0001);
      check("mode", mode_reg, 16'h0001);
      rchk(PORT_MAIN, 16'h0001, "mode read");
      wreg(16'h0000, 16'h0002);
      check("rx disabled", status, 16'h0012);
      wreg(16'h0000, 16'h0004);
      wreg(16'h000F, 16'h0000);
      wreg(16'h0000, 16'h0003);
      check("run init", status, 16'h0003);
      e = '0;
      e.setup_done = 1'b1;
      pulse(e);
      check("init done", status, 16'h01B3);
      access(PORT_POINTER, 1'b1, 16'h0005);
      // Bus config write pulse stands for one cycle only
      @(negedge clk);
      req <= '{port: PORT_BUSCFG, wr: 1'b1, rd: 1'b0, wdata: 16'h1234};
      @(negedge clk);
      check("buscfg write", {15'h0000, buscfg_wr}, 16'h0001);
      check("buscfg data", buscfg_wdata, 16'h1234);
      req <= '{port: PORT_NONE, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
      @(negedge clk);
      check("buscfg pulse", {15'h0000, buscfg_wr}, 16'h0000);
      rchk(PORT_BUSCFG, 16'hA5C3, "bus config read");
      access(PORT_POINTER, 1'b1, 16'h0055);
      rchk(PORT_MAIN, 16'h0000, "unmapped read");
      // Reset in mid-run returns pointer and status to reset values
      srst <= 1'b1;
      repeat (2) @(negedge clk);
      srst <= 1'b0;
      check("reset status", status, 16'h0004);
      check("reset pointer", {9'h000, pointer}, 16'h0000);
      rchk(PORT_POINTER, 16'h0000, "reset pointer read");
      stop_test();
   end
endmodule

`default_nettype wire
